/* File: src/qwcc_consts.vh */
`ifndef QWCC_CONSTS_VH
`define QWCC_CONSTS_VH

// Serial word layout
`define QWCC_WORD_BITS 16
`define QWCC_CMD_MSB 15
`define QWCC_CMD_LSB 12
`define QWCC_ADDR_MSB 11
`define QWCC_ADDR_LSB 8
`define QWCC_DATA_MSB 7
`define QWCC_DATA_LSB 0

// Instruction codes
`define QWCC_CMD_NOP 4'h0
`define QWCC_CMD_RESTORE 4'h1
`define QWCC_CMD_SAVE 4'h2
`define QWCC_CMD_WR_NV 4'h3
`define QWCC_CMD_HALVE_ONE 4'h4
`define QWCC_CMD_HALVE_ALL 4'h5
`define QWCC_CMD_DEC_ONE 4'h6
`define QWCC_CMD_DEC_ALL 4'h7
`define QWCC_CMD_RESET 4'h8
`define QWCC_CMD_RD_NV 4'h9
`define QWCC_CMD_RD_WIPER 4'ha
`define QWCC_CMD_WR_WIPER 4'hb
`define QWCC_CMD_DOUBLE_ONE 4'hc
`define QWCC_CMD_DOUBLE_ALL 4'hd
`define QWCC_CMD_INC_ONE 4'he
`define QWCC_CMD_INC_ALL 4'hf

// Wiper codes
`define QWCC_WIPER_BITS 6
`define QWCC_WIPER_ZERO 6'h00
`define QWCC_WIPER_MID 6'h20
`define QWCC_WIPER_FULL 6'h3f

// Nonvolatile store layout and delivered contents
`define QWCC_NV_DEPTH 16
`define QWCC_NV_WIPER_SLOTS 4
`define QWCC_NV_OUT_ADDR 4
`define QWCC_NV_WIPER_DEFAULT 8'h20
`define QWCC_NV_OUT_DEFAULT 8'h02
`define QWCC_NV_USER_DEFAULT 8'h00

// Save time: milliseconds times clock rate in kHz gives cycles
`define QWCC_SAVE_MS 25
`define QWCC_CLK_KHZ 200000
// Product of the two above, sized to the save counter so nothing is cut silently
`define QWCC_SAVE_CYCLES 23'h4c4b40

// Synchroniser reset: {wpN, presetN, chipSelN, serDataIn, serClk}
`define QWCC_SYNC_RESET 5'h1c

`endif

/* File: src/qwcc_nv_store.v */
`timescale 1ns/100ps
`default_nettype none
`include "qwcc_consts.vh"

// Nonvolatile store: one write port, one read port with registered data
module qwcc_nv_store (
  input wire clock,
  input wire rst,
  input wire clockEn,
  input wire wrEn,
  input wire [3:0] wrAddr,
  input wire [7:0] wrData,
  input wire [3:0] rdAddr,
  output reg [7:0] rdData
);

  reg [7:0] nvMem_reg [0:`QWCC_NV_DEPTH-1];
  integer i;

  // Reset restores the delivered contents; wiper slots start at midscale
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      for (i = 0; i < `QWCC_NV_DEPTH; i = i + 1) begin
        if (i < `QWCC_NV_WIPER_SLOTS)
          nvMem_reg[i] <= `QWCC_NV_WIPER_DEFAULT;
        else if (i == `QWCC_NV_OUT_ADDR)
          nvMem_reg[i] <= `QWCC_NV_OUT_DEFAULT;
        else
          nvMem_reg[i] <= `QWCC_NV_USER_DEFAULT;
      end
      rdData <= 8'h00;
    end else if (clockEn) begin
      if (wrEn)
        nvMem_reg[wrAddr] <= wrData;
      rdData <= nvMem_reg[rdAddr]; // Read-before-write on same address
    end
  end

endmodule // qwcc_nv_store
`default_nettype wire

/* File: src/qwcc_top.v */
`timescale 1ns/100ps
`default_nettype none
`include "qwcc_consts.vh"

// Contract
// R1: Wiper register value directly sets wiper position
// R2: Decode codes zero through seven as listed
// R3: Decode codes eight through fifteen as listed
// R4: Save takes 25 ms, input locked
// R5: Ready output signals save completion
// R6: Save word stores wiper; output returns previous
// R7: Power-on loads wipers from nonvolatile store
// R8: Nonvolatile wiper slots default to midscale
// R9: Preset low midscale; rising edge reloads
// R10: Bare chip-select strobe repeats step command
// R11: Write protect blocks changes except reload
// R12: Host sends no-op before releasing protect
// R13: Steps move one code, shifts factor two
// R14: Sixteen-bit word, most significant bit first
// R15: Execute only when chip select rises
// R16: Wiper writes use six low bits
// R17: Ready also marks commands 2,3,8,9,10, preset; the code leaves ready high for command 10
// R18: Increment and left shift saturate at full
// R19: Commands during save ignored, ready stays low
module qwcc_top #(
  parameter [22:0] SAVE_CYCLES = `QWCC_SAVE_CYCLES
) (
  input wire clock,
  input wire rst,
  input wire clockEn,
  input wire serClk,
  input wire serDataIn,
  input wire chipSelN,
  input wire presetN,
  input wire writeProtN,
  output reg serDataOut,
  output reg serDataOutEnN,
  output reg readyOut,
  output reg readyOutEnN,
  output wire [5:0] wiper0,
  output wire [5:0] wiper1,
  output wire [5:0] wiper2,
  output wire [5:0] wiper3
);

  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_LOAD = 4'h2;
  localparam [3:0] ST_SAVE = 4'h4;
  localparam [3:0] ST_READ = 4'h8;

  // Step operation on one wiper code
  function [5:0] stepCode;
    input [3:0] cmd;
    input [5:0] val;
    begin
      case (cmd)
        `QWCC_CMD_HALVE_ONE, `QWCC_CMD_HALVE_ALL: stepCode = {1'b0, val[5:1]};
        `QWCC_CMD_DEC_ONE, `QWCC_CMD_DEC_ALL:
          stepCode = (val == `QWCC_WIPER_ZERO) ? val : val - 6'h01;
        `QWCC_CMD_DOUBLE_ONE, `QWCC_CMD_DOUBLE_ALL:
          stepCode = val[5] ? `QWCC_WIPER_FULL : {val[4:0], 1'b0};
        `QWCC_CMD_INC_ONE, `QWCC_CMD_INC_ALL:
          stepCode = (val == `QWCC_WIPER_FULL) ? val : val + 6'h01;
        default: stepCode = val;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection

  reg [4:0] pinMeta_reg;
  reg [4:0] pinSync_reg;
  reg [4:0] pinPrev_reg;
  wire sckNow = pinSync_reg[0];
  wire dinNow = pinSync_reg[1];
  wire csNow = pinSync_reg[2];
  wire prNow = pinSync_reg[3];
  wire wpNow = pinSync_reg[4];
  wire sckRise = sckNow & ~pinPrev_reg[0];
  wire sckFall = ~sckNow & pinPrev_reg[0];
  wire csFall = ~csNow & pinPrev_reg[2];
  wire csRise = csNow & ~pinPrev_reg[2];
  wire prRise = prNow & ~pinPrev_reg[3];

  // Two flops before any logic reads a pin
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      pinMeta_reg <= `QWCC_SYNC_RESET;
      pinSync_reg <= `QWCC_SYNC_RESET;
      pinPrev_reg <= `QWCC_SYNC_RESET;
    end else if (clockEn) begin
      pinMeta_reg <= {writeProtN, presetN, chipSelN, serDataIn, serClk};
      pinSync_reg <= pinMeta_reg;
      pinPrev_reg <= pinSync_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control state

  reg [3:0] state_reg;
  reg [15:0] shift_reg;
  reg [4:0] bitCount_reg;
  reg [15:0] lastWord_reg;
  reg repeatOk_reg;
  reg [23:0] wiperBank_reg;
  reg [1:0] loadAddr_reg;
  reg [1:0] loadLast_reg;
  reg loadPhase_reg;
  reg [3:0] readAddr_reg;
  reg [22:0] saveCnt_reg;
  reg nvWrEn_reg;
  reg [3:0] nvWrAddr_reg;
  reg [7:0] nvWrData_reg;
  wire [7:0] nvRdData;
  wire [3:0] nvRdAddr = (state_reg == ST_READ) ? readAddr_reg : {2'b00, loadAddr_reg};

  // Full word executes itself; a bare strobe re-runs the last step word
  wire fullWord = bitCount_reg[4];
  wire [15:0] execWord = fullWord ? shift_reg : lastWord_reg;
  wire [3:0] eCmd = execWord[`QWCC_CMD_MSB:`QWCC_CMD_LSB];
  wire [3:0] eAddr = execWord[`QWCC_ADDR_MSB:`QWCC_ADDR_LSB];
  wire [7:0] eData = execWord[`QWCC_DATA_MSB:`QWCC_DATA_LSB];
  wire protect = ~wpNow;
  wire isStep = eCmd[2];
  // R15 execute on rise
  wire execGo = csRise & prNow & (state_reg == ST_IDLE) & (fullWord |
    ((bitCount_reg == 5'h00) & repeatOk_reg));

  assign wiper0 = wiperBank_reg[5:0];
  assign wiper1 = wiperBank_reg[11:6];
  assign wiper2 = wiperBank_reg[17:12];
  assign wiper3 = wiperBank_reg[23:18];

  qwcc_nv_store nvStore (
    .clock(clock),
    .rst(rst),
    .clockEn(clockEn),
    .wrEn(nvWrEn_reg),
    .wrAddr(nvWrAddr_reg),
    .wrData(nvWrData_reg),
    .rdAddr(nvRdAddr),
    .rdData(nvRdData)
  );

  integer i;

  ////////////////////////////////////////////////////////////////////////////
  // Serial shift, command execution, reload and save sequencing

  // R7 power-on reload starts in the load state with ready low
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= ST_LOAD;
      shift_reg <= 16'h0000;
      bitCount_reg <= 5'h00;
      lastWord_reg <= 16'h0000;
      repeatOk_reg <= 1'b0;
      wiperBank_reg <= {4{`QWCC_WIPER_MID}};
      loadAddr_reg <= 2'h0;
      loadLast_reg <= 2'h3;
      loadPhase_reg <= 1'b0;
      readAddr_reg <= 4'h0;
      saveCnt_reg <= 23'h000000;
      nvWrEn_reg <= 1'b0;
      nvWrAddr_reg <= 4'h0;
      nvWrData_reg <= 8'h00;
      serDataOut <= 1'b0;
      serDataOutEnN <= 1'b1;
      readyOut <= 1'b0;
      readyOutEnN <= 1'b0;
    end else if (clockEn) begin
      nvWrEn_reg <= 1'b0;
      // R4 shifter locked while a save runs; R14 MSB first
      if (csFall)
        bitCount_reg <= 5'h00;
      else if (!csNow && sckRise && state_reg != ST_SAVE) begin
        shift_reg <= {shift_reg[14:0], dinNow};
        if (!fullWord)
          bitCount_reg <= bitCount_reg + 5'h01;
      end
      // R6 output replays the previous word; open drain only pulls low
      if (csRise)
        serDataOutEnN <= 1'b1;
      else if (csFall || (!csNow && sckFall))
        serDataOutEnN <= shift_reg[15];

      case (state_reg)
        ST_IDLE: begin
          // R9 preset low holds midscale, rising edge reloads all
          if (!prNow) begin
            wiperBank_reg <= {4{`QWCC_WIPER_MID}};
            readyOutEnN <= 1'b0;
          end else if (prRise) begin
            state_reg <= ST_LOAD;
            loadAddr_reg <= 2'h0;
            loadLast_reg <= 2'h3;
            loadPhase_reg <= 1'b0;
          end else if (execGo) begin
            // R10 step and shift words are remembered for repeats
            if (fullWord) begin
              lastWord_reg <= shift_reg;
              repeatOk_reg <= isStep;
            end
            // R2 codes zero to seven; R3 codes eight to fifteen
            case (eCmd)
              `QWCC_CMD_RESTORE, `QWCC_CMD_RESET: begin
                // R11 reset code reloads even when protected
                if (!protect || eCmd == `QWCC_CMD_RESET) begin
                  state_reg <= ST_LOAD;
                  loadAddr_reg <= eAddr[1:0];
                  loadLast_reg <= eAddr[1:0];
                  loadPhase_reg <= 1'b0;
                  // R17 ready marks the reset code
                  if (eCmd == `QWCC_CMD_RESET)
                    readyOutEnN <= 1'b0;
                end
              end
              `QWCC_CMD_SAVE, `QWCC_CMD_WR_NV: begin
                // R11 protect blocks stores as well
                if (!protect) begin
                  nvWrEn_reg <= 1'b1;
                  nvWrAddr_reg <= (eCmd == `QWCC_CMD_SAVE) ? {2'b00, eAddr[1:0]} : eAddr;
                  nvWrData_reg <= (eCmd == `QWCC_CMD_SAVE) ?
                    {2'b00, wiperBank_reg[eAddr[1:0]*6 +: 6]} : eData;
                  state_reg <= ST_SAVE;
                  saveCnt_reg <= SAVE_CYCLES - 23'h000001;
                  readyOutEnN <= 1'b0;
                end
              end
              `QWCC_CMD_RD_NV: begin
                state_reg <= ST_READ;
                readAddr_reg <= eAddr;
                loadPhase_reg <= 1'b0;
                readyOutEnN <= 1'b0;
              end
              `QWCC_CMD_RD_WIPER: begin
                // R17 wiper readback completes at once
                shift_reg <= {8'h00, 2'b00, wiperBank_reg[eAddr[1:0]*6 +: 6]};
                readyOutEnN <= 1'b1;
              end
              `QWCC_CMD_WR_WIPER: begin
                // R16 six low data bits; R1 code sets position
                if (!protect)
                  wiperBank_reg[eAddr[1:0]*6 +: 6] <= eData[5:0];
              end
              `QWCC_CMD_HALVE_ONE, `QWCC_CMD_DEC_ONE,
              `QWCC_CMD_DOUBLE_ONE, `QWCC_CMD_INC_ONE: begin
                // R13 one step or factor two; R18 saturate at full
                if (!protect)
                  wiperBank_reg[eAddr[1:0]*6 +: 6] <=
                    stepCode(eCmd, wiperBank_reg[eAddr[1:0]*6 +: 6]);
              end
              `QWCC_CMD_HALVE_ALL, `QWCC_CMD_DEC_ALL,
              `QWCC_CMD_DOUBLE_ALL, `QWCC_CMD_INC_ALL: begin
                if (!protect)
                  for (i = 0; i < 4; i = i + 1)
                    wiperBank_reg[i*6 +: 6] <= stepCode(eCmd, wiperBank_reg[i*6 +: 6]);
              end
              default: begin
              end
            endcase
          end
        end
        ST_LOAD: begin
          // R8 slots read midscale until saved; one slot per two cycles
          loadPhase_reg <= ~loadPhase_reg;
          if (loadPhase_reg) begin
            wiperBank_reg[loadAddr_reg*6 +: 6] <= nvRdData[5:0];
            if (loadAddr_reg == loadLast_reg) begin
              state_reg <= ST_IDLE;
              readyOutEnN <= 1'b1;
            end else
              loadAddr_reg <= loadAddr_reg + 2'h1;
          end
        end
        ST_SAVE: begin
          // R19 strobes ignored and ready low until the save ends; R5
          if (saveCnt_reg == 23'h000000) begin
            state_reg <= ST_IDLE;
            readyOutEnN <= 1'b1;
          end else
            saveCnt_reg <= saveCnt_reg - 23'h000001;
        end
        ST_READ: begin
          // Stored byte waits in the shifter for the next frame
          loadPhase_reg <= ~loadPhase_reg;
          if (loadPhase_reg) begin
            shift_reg <= {8'h00, nvRdData};
            state_reg <= ST_IDLE;
            readyOutEnN <= 1'b1;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule // qwcc_top
`default_nettype wire

/* File: testbench/qwcc_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
// Checks seen from the block's pins only
module qwcc_assertions (
  input wire logic clock,
  input wire logic rst,
  input wire logic chipSelN,
  input wire logic presetN,
  input wire logic writeProtN,
  input wire logic serDataOut,
  input wire logic serDataOutEnN,
  input wire logic readyOut,
  input wire logic readyOutEnN,
  input wire logic [5:0] wiper0,
  input wire logic [5:0] wiper1,
  input wire logic [5:0] wiper2,
  input wire logic [5:0] wiper3
);
  logic [23:0] allW;
  // All four wipers as one word; all midscale reads 820820
  assign allW = {wiper3, wiper2, wiper1, wiper0};
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  property p_por_load;
    $fell(rst) |-> (allW == 24'h820820 && !readyOutEnN) ##[1:12] readyOutEnN;
  endproperty
  a_por_load: assert property (p_por_load) else $error("reset reload wrong");
  property p_od_low;
    !serDataOut && !readyOut;
  endproperty
  a_od_low: assert property (p_od_low) else $error("open drain level");
  property p_sdo_idle;
    chipSelN [*6] |-> serDataOutEnN;
  endproperty
  a_sdo_idle: assert property (p_sdo_idle) else $error("data out while idle");
  property p_preset_mid;
    (readyOutEnN && presetN) ##1 !presetN [*6] |-> allW == 24'h820820;
  endproperty
  a_preset_mid: assert property (p_preset_mid) else $error("preset not mid");
  property p_preset_reload;
    !presetN [*6] ##1 presetN |-> ##[1:16] readyOutEnN;
  endproperty
  a_preset_reload: assert property (p_preset_reload) else $error("preset hang");
  property p_ready_cause;
    $fell(readyOutEnN) |-> $past(chipSelN, 2) || !$past(presetN, 2);
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("busy w/o cause");
  property p_wiper_cause;
    (allW != $past(allW) && $past(readyOutEnN)) |-> $past(chipSelN, 2) || !$past(presetN, 2);
  endproperty
  a_wiper_cause: assert property (p_wiper_cause) else $error("wiper w/o cause");
  property p_wp_hold;
    (!writeProtN && presetN) [*6] ##0 (readyOutEnN && $past(readyOutEnN)) |-> allW == $past(allW);
  endproperty
  a_wp_hold: assert property (p_wp_hold) else $error("protected wiper moved");
endmodule // qwcc_assertions
bind qwcc_top qwcc_assertions u_chk (.clock(clock), .rst(rst), .chipSelN(chipSelN),
  .presetN(presetN), .writeProtN(writeProtN), .serDataOut(serDataOut),
  .serDataOutEnN(serDataOutEnN), .readyOut(readyOut), .readyOutEnN(readyOutEnN),
  .wiper0(wiper0), .wiper1(wiper1), .wiper2(wiper2), .wiper3(wiper3));
`default_nettype wire

/* File: testbench/qwcc_spi_host.sv */
`timescale 1ns/100ps
`default_nettype none
// Host side of the link, mode 0; its clock stands low between frames
module qwcc_spi_host (
  input wire logic clock,
  input wire logic sdoEnN,
  output logic serClk,
  output logic serDataIn,
  output logic chipSelN
);
  initial begin
    serClk = 1'b0;
    serDataIn = 1'b0;
    chipSelN = 1'b1;
  end
  ////////////////////////////////////////////////////////////
  // Half of a 160 ns link period
  task automatic half();
    repeat (16) @(posedge clock);
  endtask
  // msb first, select held over the word
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    chipSelN <= 1'b0;
    half();
    for (int i = 0; i < n; i++) begin
      serDataIn <= w[15 - i];
      half();
      serClk <= 1'b1;
      // pull-up makes a released line read one
      rx = {rx[14:0], sdoEnN};
      half();
      serClk <= 1'b0;
    end
    half();
    chipSelN <= 1'b1;
    // Released data line flips so a stale bit never looks driven
    serDataIn <= ~serDataIn;
    half();
  endtask
endmodule // qwcc_spi_host
`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for the wiper command block
module testbench;
  localparam [22:0] SAVE = 23'h0003e8; // Save outlasts one whole frame
  logic clock, rst, clockEn, presetN, writeProtN;
  logic serClk, serDataIn, chipSelN, sdoEnN, rdyEnN;
  logic [5:0] w0, w1, w2, w3;
  logic [15:0] rx;
  int err_total = 0;
  int total_checks = 0;
  // Word, wiper1, wiper3 expected; word 0001 marks a bare strobe
  logic [31:0] stepTbl [0:13] = '{32'hb13e3e20, 32'he1003f20, 32'h00013f20, 32'h61003e20,
    32'h41001f20, 32'h00010f20, 32'hc1001e20, 32'hf0001f21, 32'hd0003e3f, 32'h50001f1f,
    32'h70001e1e, 32'h00011d1d, 32'h00001d1d, 32'h00011d1d};
  qwcc_top #(.SAVE_CYCLES(SAVE)) dut (.clock(clock), .rst(rst), .clockEn(clockEn),
    .serClk(serClk), .serDataIn(serDataIn), .chipSelN(chipSelN), .presetN(presetN),
    .writeProtN(writeProtN), .serDataOut(), .serDataOutEnN(sdoEnN), .readyOut(),
    .readyOutEnN(rdyEnN), .wiper0(w0), .wiper1(w1), .wiper2(w2), .wiper3(w3));
  qwcc_spi_host host (.clock(clock), .sdoEnN(sdoEnN), .serClk(serClk),
    .serDataIn(serDataIn), .chipSelN(chipSelN));
  // 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // One compare, every value widened to 24 bits
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [15:0] w);
    host.xfer(w, 16, rx);
  endtask
  // Bounded wait; running out is a mismatch and ends the run
  task automatic waitRdy();
    int n;
    n = 0;
    while (rdyEnN !== 1'b1 && n < 5000) begin
      @(posedge clock);
      n++;
    end
    chk({23'h0, rdyEnN}, 24'h000001);
    if (n >= 5000) begin
      wrap_up();
    end
  endtask
  task automatic t_por();
    waitRdy();
    chk({w3, w2, w1, w0}, 24'h820820);
  endtask
  task automatic t_save();
    send(16'hb0d0);
    chk({18'h0, w0}, 24'h000010);
    send(16'h2000);
    chk({8'h0, rx}, 24'h00b0d0);
    send(16'hb03f);
    chk({18'h0, w0}, 24'h000010);
    chk({23'h0, rdyEnN}, 24'h000000);
    waitRdy();
    presetN <= 1'b0;
    repeat (12) @(posedge clock);
    chk({w3, w2, w1, w0}, 24'h820820);
    presetN <= 1'b1;
    waitRdy();
    chk({18'h0, w0}, 24'h000010);
  endtask
  task automatic t_steps();
    for (int i = 0; i < 14; i++) begin
      host.xfer(stepTbl[i][31:16], (stepTbl[i][31:16] == 16'h0001) ? 0 : 16, rx);
      chk({18'h0, w1}, {16'h0, stepTbl[i][15:8]});
      chk({18'h0, w3}, {16'h0, stepTbl[i][7:0]});
    end
  endtask
  // Clock enable low: a whole frame passes unseen, nothing executes
  task automatic t_freeze();
    clockEn <= 1'b0;
    send(16'he100);
    clockEn <= 1'b1;
    repeat (8) @(posedge clock);
    chk({18'h0, w1}, 24'h00001d);
    chk({23'h0, rdyEnN}, 24'h000001);
  endtask
  task automatic t_nv();
    send(16'h35a5);
    waitRdy();
    send(16'h9500);
    waitRdy();
    send(16'h0000);
    chk({8'h0, rx}, 24'h0000a5);
    send(16'ha100);
    send(16'h0000);
    chk({8'h0, rx}, 24'h00001d);
    send(16'hb22a);
    send(16'h1200);
    chk({18'h0, w2}, 24'h000020);
  endtask
  task automatic t_wp();
    send(16'hb22a);
    writeProtN <= 1'b0;
    repeat (8) @(posedge clock);
    send(16'hb211);
    send(16'he200);
    chk({18'h0, w2}, 24'h00002a);
    send(16'h8200);
    waitRdy();
    chk({18'h0, w2}, 24'h000020);
    send(16'h0000);
    writeProtN <= 1'b1;
  endtask
  // Reset, then each scenario in turn
  initial begin
    rst = 1'b1;
    clockEn = 1'b1;
    presetN = 1'b1;
    writeProtN = 1'b1;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    t_por();
    t_save();
    t_steps();
    t_freeze();
    t_nv();
    t_wp();
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
